// *** pkg/ifc_map.vh ***
// ifc_map.vh: constants of the interface configuration controller
`ifndef IFC_MAP_VH
`define IFC_MAP_VH

// timing
`define IFC_CLK_KHZ 50000
`define IFC_QUIET_MS 4000
`define IFC_FLASH_MS 250
`define IFC_DP_STEP_MS 50
// cycle counts at the core clock, sized to the 28-bit counters
`define IFC_QUIET_CYC 28'hBEBC200
`define IFC_FLASH_CYC 28'h0BEBC20
`define IFC_DP_CYC 28'h02625A0

// input rate classification, kHz
`define IFC_DS_MIN_KHZ 8'h3C
`define IFC_DS_MAX_KHZ 8'h64
`define IFC_QS_MIN_KHZ 8'hA2
`define IFC_QS_MAX_KHZ 8'hC8

// internal base rates, units of 100 Hz
`define IFC_RATE_44_X10 11'h1B9
`define IFC_RATE_48_X10 11'h1E0

// speed range codes
`define IFC_SPD_SS 2'h0
`define IFC_SPD_DS 2'h1
`define IFC_SPD_QS 2'h2

// clock source index in the stored word
`define IFC_CK_AES 3'h0
`define IFC_CK_MADI 3'h1
`define IFC_CK_WCK 3'h2
`define IFC_CK_I44 3'h3
`define IFC_CK_I48 3'h4

// stored settings word layout
`define IFC_SW_W 11
`define IFC_SW_CLK 0
`define IFC_SW_SPD 3
`define IFC_SW_FMT 5
`define IFC_SW_FRM 6
`define IFC_SW_COAX 7
`define IFC_SW_REM 8
`define IFC_SW_OFS 9
`define IFC_SW_AUTO 10

// routing matrix
`define IFC_N_OUT 7'h4A
`define IFC_N_IN 7'h48
`define IFC_RT_MUTE 8'h80

`endif

// *** design/ifc_route_mem.v ***
// ifc_route_mem.v: routing table, one source entry per output
`timescale 1ns/1ps
`default_nettype none
`include "ifc_map.vh"
module ifc_route_mem #(
	parameter DEPTH = 74,
	parameter AW = 7,
	parameter DW = 8
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// write port
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [DW-1:0] wdata,
	// read port
	input wire [AW-1:0] raddr,
	output reg [DW-1:0] rdata_r
);

reg [DW-1:0] mem [0:DEPTH-1];

always @(posedge clk) begin
	if (we)
		mem[waddr] <= wdata;
end

always @(posedge clk) begin
	if (rst)
		rdata_r <= `IFC_RT_MUTE;
	else
		rdata_r <= mem[raddr];
end

endmodule
`default_nettype wire

// *** design/ifc_ctrl.v ***
// ifc_ctrl.v: configuration and state indication controller of the converter
// Overview of operation
// - AES double-speed LED for 60..100 kHz
// - AES quad-speed LED for 162..200 kHz
// - clock button cycles AES, link, word, 44.1, 48
// - speed range multiplies the internal base rate
// - output format selects 56 or 64 channels
// - 96k framing only when double speed permits
// - input selector picks optical or coaxial port
// - fourteen multichannel input state indicators
// - input sync LED shows sync to reference
// - per-AES sync LED flashes when locked unsynced
// - one audio-presence LED per AES input
// - remote commands via MIDI ports or link
// - matrix always active, output chosen then input
// - each output holds one source, no summing
// - store settings after 4 s quiet, restore
// - moving decimal point while storing
// - group audio LED on any nonzero channel
// - lowest locked AES input is reference
// - sync LED steady when synced, flashes when locked unsynced, dark without lock
`timescale 1ns/1ps
`default_nettype none
`include "ifc_map.vh"
module ifc_ctrl #(
	parameter [27:0] QUIET_CYC = `IFC_QUIET_CYC,
	parameter [27:0] FLASH_CYC = `IFC_FLASH_CYC,
	parameter [27:0] DP_CYC = `IFC_DP_CYC,
	parameter N_AES = 4
) (
	// clock and reset
	input wire CORE_CLK,
	input wire RST,
	// front panel buttons, asynchronous
	input wire BTN_IN_PORT,
	input wire BTN_FORMAT,
	input wire BTN_FRAME,
	input wire BTN_CLOCK,
	input wire BTN_SPEED,
	input wire BTN_REMOTE,
	input wire BTN_OFFSET,
	input wire BTN_AUTO,
	// routing edit from panel logic
	input wire ROUTE_OUT_STB,
	input wire [6:0] ROUTE_OUT_SEL,
	input wire ROUTE_IN_STB,
	input wire [6:0] ROUTE_IN_SEL,
	input wire ROUTE_MUTE_STB,
	// routing lookup for the datapath
	input wire [6:0] ROUTE_RD_ADDR,
	output wire [6:0] ROUTE_RD_SRC,
	output wire ROUTE_RD_MUTE,
	output wire ROUTE_READY,
	// AES receivers
	input wire [N_AES*8-1:0] AES_RATE_KHZ,
	input wire [N_AES-1:0] AES_LOCK,
	input wire [N_AES-1:0] AES_SYNC,
	input wire [N_AES-1:0] AES_AUDIO,
	output reg [N_AES-1:0] LED_AES_DS,
	output reg [N_AES-1:0] LED_AES_QS,
	output reg [N_AES-1:0] LED_AES_SYNC,
	output reg [N_AES-1:0] LED_AES_AUDIO,
	// multichannel receiver
	input wire MADI_LOCK,
	input wire MADI_SYNC,
	input wire MADI_AUTO,
	input wire MADI_IS64,
	input wire MADI_IS96,
	input wire [63:0] MADI_CH_NZ,
	output reg LED_IN_COAX,
	output reg LED_IN_AUTO,
	output reg LED_IN_ERR,
	output reg LED_IN_SYNC,
	output reg LED_IN_64,
	output reg LED_IN_96,
	output reg [7:0] LED_IN_AUDIO,
	// word clock receiver
	input wire WCK_LOCK,
	// configuration
	output wire IN_SEL_COAX,
	output wire OUT_FMT_64,
	output wire OUT_FRAME_96,
	output wire REMOTE_VIA_LINK,
	output wire OFFSET_EN,
	output wire AUTO_ASSIGN,
	output wire [4:0] CLK_SEL,
	output wire [1:0] SPEED_RANGE,
	output reg [10:0] INT_RATE_X10,
	output reg [1:0] AES_REF_IDX,
	output reg REF_VALID,
	output reg [4:0] LED_CLK,
	output reg LED_DS,
	output reg LED_QS,
	// settings storage
	output reg NV_STORE,
	output reg [`IFC_SW_W-1:0] NV_WR_DATA,
	input wire NV_DONE,
	input wire NV_RESTORE_VALID,
	input wire [`IFC_SW_W-1:0] NV_RESTORE_DATA,
	output wire STORE_BUSY,
	output reg [3:0] DP_POS
);

localparam [4:0] CK_AES = 5'h01;
localparam [4:0] CK_MADI = 5'h02;
localparam [4:0] CK_WCK = 5'h04;
localparam [4:0] CK_I44 = 5'h08;
localparam [4:0] CK_I48 = 5'h10;
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_REQ = 3'h2;
localparam [2:0] ST_BUSY = 3'h4;

// button synchronisers and press detect
wire [7:0] btn_raw = {BTN_AUTO, BTN_OFFSET, BTN_REMOTE, BTN_SPEED,
	BTN_CLOCK, BTN_FRAME, BTN_FORMAT, BTN_IN_PORT};
reg [7:0] btn_s1_r;
reg [7:0] btn_s2_r;
reg [7:0] btn_d_r;
wire [7:0] press = btn_s2_r & ~btn_d_r;

always @(posedge CORE_CLK) begin
	if (RST) begin
		btn_s1_r <= 8'h00;
		btn_s2_r <= 8'h00;
		btn_d_r <= 8'h00;
	end else begin
		btn_s1_r <= btn_raw;
		btn_s2_r <= btn_s1_r;
		btn_d_r <= btn_s2_r;
	end
end

// settings state
reg [4:0] clk_r;
reg [4:0] clk_nxt;
reg [1:0] spd_r;
reg fmt_r;
reg frm_r;
reg coax_r;
reg rem_r;
reg ofs_r;
reg auto_r;
reg [2:0] rs_idx;
reg [4:0] rs_clk;

always @* begin
	case (clk_r)
		CK_AES: clk_nxt = CK_MADI;
		CK_MADI: clk_nxt = CK_WCK;
		CK_WCK: clk_nxt = CK_I44;
		CK_I44: clk_nxt = CK_I48;
		default: clk_nxt = CK_AES;
	endcase
end

always @* begin
	rs_idx = NV_RESTORE_DATA[`IFC_SW_CLK+2:`IFC_SW_CLK];
	case (rs_idx)
		`IFC_CK_AES: rs_clk = CK_AES;
		`IFC_CK_MADI: rs_clk = CK_MADI;
		`IFC_CK_WCK: rs_clk = CK_WCK;
		`IFC_CK_I44: rs_clk = CK_I44;
		default: rs_clk = CK_I48;
	endcase
end

always @(posedge CORE_CLK) begin
	if (RST) begin
		clk_r <= CK_I48;
		spd_r <= `IFC_SPD_SS;
		fmt_r <= 1'b0;
		frm_r <= 1'b0;
		coax_r <= 1'b0;
		rem_r <= 1'b0;
		ofs_r <= 1'b0;
		auto_r <= 1'b0;
	end else if (NV_RESTORE_VALID) begin
		clk_r <= rs_clk;
		if (NV_RESTORE_DATA[`IFC_SW_SPD+1:`IFC_SW_SPD] == `IFC_SPD_QS)
			spd_r <= `IFC_SPD_QS;
		else
			spd_r <= NV_RESTORE_DATA[`IFC_SW_SPD+1:`IFC_SW_SPD] & `IFC_SPD_DS;
		fmt_r <= NV_RESTORE_DATA[`IFC_SW_FMT];
		frm_r <= NV_RESTORE_DATA[`IFC_SW_FRM];
		coax_r <= NV_RESTORE_DATA[`IFC_SW_COAX];
		rem_r <= NV_RESTORE_DATA[`IFC_SW_REM];
		ofs_r <= NV_RESTORE_DATA[`IFC_SW_OFS];
		auto_r <= NV_RESTORE_DATA[`IFC_SW_AUTO] & NV_RESTORE_DATA[`IFC_SW_OFS];
	end else begin
		if (press[0])
			coax_r <= ~coax_r;
		if (press[1])
			fmt_r <= ~fmt_r;
		if (press[2])
			frm_r <= ~frm_r;
		if (press[3])
			clk_r <= clk_nxt;
		if (press[4]) begin
			if (spd_r == `IFC_SPD_SS)
				spd_r <= `IFC_SPD_DS;
			else if (spd_r == `IFC_SPD_DS)
				spd_r <= `IFC_SPD_QS;
			else
				spd_r <= `IFC_SPD_SS;
		end
		if (press[5])
			rem_r <= ~rem_r;
		if (press[6])
			ofs_r <= ~ofs_r;
		if (!ofs_r || press[6])
			auto_r <= 1'b0;
		else if (press[7])
			auto_r <= ~auto_r;
	end
end

assign IN_SEL_COAX = coax_r;
assign OUT_FMT_64 = fmt_r;
assign OUT_FRAME_96 = frm_r & (spd_r == `IFC_SPD_DS);
assign REMOTE_VIA_LINK = rem_r;
assign OFFSET_EN = ofs_r;
assign AUTO_ASSIGN = auto_r;
assign CLK_SEL = clk_r;
assign SPEED_RANGE = spd_r;

// reference selection
reg [1:0] aes_ref;
reg ref_ok;
integer i;

always @* begin
	aes_ref = 2'h0;
	for (i = N_AES - 1; i >= 0; i = i - 1) begin
		if (AES_LOCK[i])
			aes_ref = i[1:0];
	end
	case (clk_r)
		CK_AES: ref_ok = |AES_LOCK;
		CK_MADI: ref_ok = MADI_LOCK;
		CK_WCK: ref_ok = WCK_LOCK;
		default: ref_ok = 1'b1;
	endcase
end

// flash and moving point dividers
reg [27:0] fl_cnt_r;
reg flash_r;
reg [27:0] dp_cnt_r;
wire dp_step = (dp_cnt_r == DP_CYC - 28'h0000001);
reg [2:0] st_r;

always @(posedge CORE_CLK) begin
	if (RST) begin
		fl_cnt_r <= 28'h0000000;
		flash_r <= 1'b0;
		dp_cnt_r <= 28'h0000000;
	end else begin
		if (fl_cnt_r == FLASH_CYC - 28'h0000001) begin
			fl_cnt_r <= 28'h0000000;
			flash_r <= ~flash_r;
		end else begin
			fl_cnt_r <= fl_cnt_r + 28'h0000001;
		end
		if (st_r == ST_IDLE || dp_step)
			dp_cnt_r <= 28'h0000000;
		else
			dp_cnt_r <= dp_cnt_r + 28'h0000001;
	end
end

// indicators
integer k;

always @(posedge CORE_CLK) begin
	if (RST) begin
		LED_AES_DS <= {N_AES{1'b0}};
		LED_AES_QS <= {N_AES{1'b0}};
		LED_AES_SYNC <= {N_AES{1'b0}};
		LED_AES_AUDIO <= {N_AES{1'b0}};
		LED_IN_COAX <= 1'b0;
		LED_IN_AUTO <= 1'b0;
		LED_IN_ERR <= 1'b0;
		LED_IN_SYNC <= 1'b0;
		LED_IN_64 <= 1'b0;
		LED_IN_96 <= 1'b0;
		LED_IN_AUDIO <= 8'h00;
		INT_RATE_X10 <= `IFC_RATE_48_X10;
		AES_REF_IDX <= 2'h0;
		REF_VALID <= 1'b0;
		LED_CLK <= 5'h00;
		LED_DS <= 1'b0;
		LED_QS <= 1'b0;
	end else begin
		for (k = 0; k < N_AES; k = k + 1) begin
			LED_AES_DS[k] <= AES_RATE_KHZ[k*8 +: 8] >= `IFC_DS_MIN_KHZ &&
				AES_RATE_KHZ[k*8 +: 8] <= `IFC_DS_MAX_KHZ;
			LED_AES_QS[k] <= AES_RATE_KHZ[k*8 +: 8] >= `IFC_QS_MIN_KHZ &&
				AES_RATE_KHZ[k*8 +: 8] <= `IFC_QS_MAX_KHZ;
			LED_AES_SYNC[k] <= AES_LOCK[k] & (AES_SYNC[k] | flash_r);
		end
		LED_AES_AUDIO <= AES_AUDIO & AES_LOCK;
		LED_IN_COAX <= coax_r;
		LED_IN_AUTO <= MADI_AUTO;
		LED_IN_ERR <= ~MADI_LOCK;
		LED_IN_SYNC <= MADI_LOCK & (MADI_SYNC | flash_r);
		LED_IN_64 <= MADI_LOCK & MADI_IS64;
		LED_IN_96 <= MADI_LOCK & MADI_IS96;
		for (k = 0; k < 8; k = k + 1)
			LED_IN_AUDIO[k] <= MADI_LOCK & (|MADI_CH_NZ[k*8 +: 8]);
		if (clk_r == CK_I44)
			INT_RATE_X10 <= `IFC_RATE_44_X10 << spd_r;
		else
			INT_RATE_X10 <= `IFC_RATE_48_X10 << spd_r;
		AES_REF_IDX <= aes_ref;
		REF_VALID <= ref_ok;
		LED_CLK <= clk_r & {5{ref_ok | flash_r}};
		LED_DS <= (spd_r == `IFC_SPD_DS);
		LED_QS <= (spd_r == `IFC_SPD_QS);
	end
end

// routing matrix edit and reset sweep
reg [6:0] sel_out_r;
reg clr_r;
reg [6:0] clr_cnt_r;
reg rd_oor_r;
reg rt_we;
reg [6:0] rt_waddr;
reg [7:0] rt_wdata;
wire [7:0] rt_rdata;

always @* begin
	rt_we = 1'b0;
	rt_waddr = sel_out_r;
	rt_wdata = `IFC_RT_MUTE;
	if (clr_r) begin
		rt_we = 1'b1;
		rt_waddr = clr_cnt_r;
	end else if (ROUTE_IN_STB && ROUTE_IN_SEL < `IFC_N_IN) begin
		rt_we = 1'b1;
		rt_wdata = {1'b0, ROUTE_IN_SEL};
	end else if (ROUTE_MUTE_STB) begin
		rt_we = 1'b1;
	end
end

always @(posedge CORE_CLK) begin
	if (RST) begin
		sel_out_r <= 7'h00;
		clr_r <= 1'b1;
		clr_cnt_r <= 7'h00;
		rd_oor_r <= 1'b1;
	end else begin
		if (ROUTE_OUT_STB && ROUTE_OUT_SEL < `IFC_N_OUT)
			sel_out_r <= ROUTE_OUT_SEL;
		if (clr_r) begin
			clr_cnt_r <= clr_cnt_r + 7'h01;
			if (clr_cnt_r == `IFC_N_OUT - 7'h01)
				clr_r <= 1'b0;
		end
		rd_oor_r <= clr_r || ROUTE_RD_ADDR >= `IFC_N_OUT;
	end
end

ifc_route_mem #(
	.DEPTH(74),
	.AW(7),
	.DW(8)
) u_route (
	.clk(CORE_CLK),
	.rst(RST),
	.we(rt_we),
	.waddr(rt_waddr),
	.wdata(rt_wdata),
	.raddr(ROUTE_RD_ADDR),
	.rdata_r(rt_rdata)
);

assign ROUTE_RD_SRC = rt_rdata[6:0];
assign ROUTE_RD_MUTE = rt_rdata[7] | rd_oor_r;
assign ROUTE_READY = ~clr_r;

// settings store after a quiet period
reg [2:0] clk_idx;

always @* begin
	if (clk_r == CK_AES)
		clk_idx = `IFC_CK_AES;
	else if (clk_r == CK_MADI)
		clk_idx = `IFC_CK_MADI;
	else if (clk_r == CK_WCK)
		clk_idx = `IFC_CK_WCK;
	else if (clk_r == CK_I44)
		clk_idx = `IFC_CK_I44;
	else
		clk_idx = `IFC_CK_I48;
end

wire [`IFC_SW_W-1:0] sw = {auto_r, ofs_r, rem_r, coax_r, frm_r, fmt_r, spd_r, clk_idx};
reg [`IFC_SW_W-1:0] sw_prev_r;
reg rs_mask_r;
reg pend_r;
reg [27:0] q_cnt_r;
wire changed = (sw != sw_prev_r && !rs_mask_r) || (rt_we && !clr_r);
wire quiet = pend_r && q_cnt_r == QUIET_CYC - 28'h0000001;

always @(posedge CORE_CLK) begin
	if (RST) begin
		sw_prev_r <= {`IFC_SW_W{1'b0}};
		rs_mask_r <= 1'b1;
		pend_r <= 1'b0;
		q_cnt_r <= 28'h0000000;
		st_r <= ST_IDLE;
		NV_STORE <= 1'b0;
		NV_WR_DATA <= {`IFC_SW_W{1'b0}};
		DP_POS <= 4'h0;
	end else begin
		sw_prev_r <= sw;
		rs_mask_r <= NV_RESTORE_VALID;
		NV_STORE <= 1'b0;
		if (changed) begin
			pend_r <= 1'b1;
			q_cnt_r <= 28'h0000000;
		end else if (quiet && st_r == ST_IDLE) begin
			pend_r <= 1'b0;
			q_cnt_r <= 28'h0000000;
		end else if (pend_r && !quiet) begin
			q_cnt_r <= q_cnt_r + 28'h0000001;
		end
		case (st_r)
			ST_IDLE: begin
				DP_POS <= 4'h0;
				if (quiet && !changed)
					st_r <= ST_REQ;
			end
			ST_REQ: begin
				NV_STORE <= 1'b1;
				NV_WR_DATA <= sw;
				DP_POS <= 4'h1;
				st_r <= ST_BUSY;
			end
			ST_BUSY: begin
				if (dp_step)
					DP_POS <= {DP_POS[2:0], DP_POS[3]};
				if (NV_DONE)
					st_r <= ST_IDLE;
			end
			default: st_r <= ST_IDLE;
		endcase
	end
end

assign STORE_BUSY = (st_r != ST_IDLE);

endmodule
`default_nettype wire

// *** bench/ifc_ctrl_sva.sv ***
// ifc_ctrl_sva.sv: assertion checker bound to the controller top
`timescale 1ns/1ps
`default_nettype none
module ifc_ctrl_sva #(
	parameter [27:0] QUIET_CYC = 28'h0000014,
	parameter [27:0] FLASH_CYC = 28'h0000004,
	parameter [27:0] DP_CYC = 28'h0000003,
	parameter N_AES = 4
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// receivers
	input wire logic [N_AES*8-1:0] AES_RATE_KHZ,
	input wire logic [N_AES-1:0] AES_LOCK,
	input wire logic [N_AES-1:0] AES_SYNC,
	input wire logic MADI_LOCK,
	input wire logic [63:0] MADI_CH_NZ,
	// indicators
	input wire logic [N_AES-1:0] LED_AES_DS,
	input wire logic [N_AES-1:0] LED_AES_QS,
	input wire logic [N_AES-1:0] LED_AES_SYNC,
	input wire logic LED_IN_ERR,
	input wire logic [7:0] LED_IN_AUDIO,
	// configuration
	input wire logic [4:0] CLK_SEL,
	input wire logic [1:0] SPEED_RANGE,
	input wire logic [10:0] INT_RATE_X10,
	input wire logic [1:0] AES_REF_IDX,
	input wire logic OUT_FRAME_96,
	input wire logic OFFSET_EN,
	input wire logic AUTO_ASSIGN,
	// storage and routing
	input wire logic NV_STORE,
	input wire logic STORE_BUSY,
	input wire logic [3:0] DP_POS,
	input wire logic ROUTE_READY,
	input wire logic [6:0] ROUTE_RD_ADDR,
	input wire logic ROUTE_RD_MUTE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	a_ds_range: assert property (!$past(RST) && AES_RATE_KHZ[7:0] >= 8'h3C
		&& AES_RATE_KHZ[7:0] <= 8'h64 |=> LED_AES_DS[0]) else $error("double speed indicator missing");
	a_qs_range: assert property (!$past(RST) |=> LED_AES_QS[1] ==
		($past(AES_RATE_KHZ[15:8]) >= 8'hA2 && $past(AES_RATE_KHZ[15:8]) <= 8'hC8)) else $error("quad speed wrong");
	a_clk_onehot: assert property ($onehot(CLK_SEL)) else $error("clock select not one-hot");
	a_rate_mult: assert property ($stable(SPEED_RANGE) && $stable(CLK_SEL) && !$past(RST) |->
		INT_RATE_X10 == ((CLK_SEL == 5'h08 ? 11'h1B9 : 11'h1E0) << SPEED_RANGE)) else $error("internal rate wrong");
	a_frame_gate: assert property (OUT_FRAME_96 |-> SPEED_RANGE == 2'h1) else $error("96k frame outside ds");
	a_sync_lock: assert property (!$past(RST) && !AES_LOCK[0] |=> !LED_AES_SYNC[0])
		else $error("sync lit without lock");
	a_sync_steady: assert property (!$past(RST) && AES_LOCK[0] && AES_SYNC[0] |=> LED_AES_SYNC[0])
		else $error("sync not steady");
	a_grp_audio: assert property (!$past(RST) && MADI_LOCK && (|MADI_CH_NZ[23:16]) |=> LED_IN_AUDIO[2])
		else $error("group audio dark");
	a_in_err: assert property (!$past(RST) |=> LED_IN_ERR == !$past(MADI_LOCK)) else $error("error led wrong");
	a_aes_ref: assert property (!$past(RST) && AES_LOCK[1:0] == 2'b10 |=> AES_REF_IDX == 2'h1)
		else $error("reference not lowest");
	a_auto_gate: assert property (AUTO_ASSIGN |-> OFFSET_EN) else $error("auto without offset");
	a_store_start: assert property ($rose(STORE_BUSY) |-> ##[0:1] NV_STORE) else $error("store not issued");
	a_store_point: assert property (NV_STORE |-> STORE_BUSY && DP_POS == 4'h1) else $error("point not moving");
	a_idle_point: assert property (!STORE_BUSY && !$past(STORE_BUSY) |-> DP_POS == 4'h0)
		else $error("point while idle");
	a_route_mute: assert property (ROUTE_READY && $past(ROUTE_READY) && $past(ROUTE_RD_ADDR) >= 7'h4A
		|-> ROUTE_RD_MUTE) else $error("absent output not muted");
endmodule
bind ifc_ctrl ifc_ctrl_sva #(.QUIET_CYC(QUIET_CYC), .FLASH_CYC(FLASH_CYC), .DP_CYC(DP_CYC), .N_AES(N_AES))
	chk_u (.*);
`default_nettype wire

// *** bench/ifc_panel_model.sv ***
// ifc_panel_model.sv: front panel buttons and settings storage responder
`timescale 1ns/1ps
`default_nettype none
module ifc_panel_model (
	// clock
	input wire logic clk,
	// storage handshake
	input wire logic store,
	output logic done,
	// button levels, high while pressed
	output logic [7:0] btn
);
	int dly = 1;
	initial begin
		done = 1'b0;
		btn = 8'h00;
	end
	// held past the two-flop synchroniser
	task automatic press(input int i);
		@(posedge clk);
		#1 btn[i] = 1'b1;
		repeat (4) @(posedge clk);
		#1 btn[i] = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// storage finishes dly cycles after the request
	always begin
		@(posedge clk);
		#1;
		if (store === 1'b1) begin
			repeat (dly) @(posedge clk);
			#1 done = 1'b1;
			@(posedge clk);
			#1 done = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// testbench.sv: self-checking bench of the interface configuration controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst, m_lock, m_64, o_stb, i_stb, m_stb, rv, nv_done, rd_mute, rdy, in_err, in64;
	logic sel_coax, fmt64, frm96, rem, ofs, auto_a, nv_store, busy;
	logic m_sync, m_auto, m_96, wck, in_coax, in_auto, in_sync, in96, ref_ok, ds, qs;
	logic [3:0] aes_lock, aes_sync, aes_audio, led_ds, led_qs, led_sync, led_audio, dp;
	logic [6:0] o_sel, i_sel, rd_addr, rd_src;
	logic [10:0] rdat, rate_x10, nv_data;
	logic [31:0] rate;
	logic [63:0] m_nz;
	logic [7:0] in_audio, btn;
	logic [4:0] clk_sel, led_clk;
	logic [1:0] spd, ref_idx;
	logic [2:0] seen;
	logic [7:0] rt [8] = '{8'h3B, 8'h3C, 8'h64, 8'h65, 8'hA1, 8'hA2, 8'hC8, 8'hC9};
	int n, n_checks, miscompares;
	ifc_panel_model panel_u (.clk(clk), .store(nv_store), .done(nv_done), .btn(btn));
	ifc_ctrl #(.QUIET_CYC(28'h0000014), .FLASH_CYC(28'h0000004), .DP_CYC(28'h0000003)) dut_u (
		.CORE_CLK(clk), .RST(rst), .BTN_IN_PORT(btn[0]), .BTN_FORMAT(btn[1]), .BTN_FRAME(btn[2]),
		.BTN_CLOCK(btn[3]), .BTN_SPEED(btn[4]), .BTN_REMOTE(btn[5]), .BTN_OFFSET(btn[6]), .BTN_AUTO(btn[7]),
		.ROUTE_OUT_STB(o_stb), .ROUTE_OUT_SEL(o_sel), .ROUTE_IN_STB(i_stb), .ROUTE_IN_SEL(i_sel),
		.ROUTE_MUTE_STB(m_stb), .ROUTE_RD_ADDR(rd_addr), .ROUTE_RD_SRC(rd_src), .ROUTE_RD_MUTE(rd_mute),
		.ROUTE_READY(rdy), .AES_RATE_KHZ(rate), .AES_LOCK(aes_lock), .AES_SYNC(aes_sync), .AES_AUDIO(aes_audio),
		.LED_AES_DS(led_ds), .LED_AES_QS(led_qs), .LED_AES_SYNC(led_sync), .LED_AES_AUDIO(led_audio),
		.MADI_LOCK(m_lock), .MADI_SYNC(m_sync), .MADI_AUTO(m_auto), .MADI_IS64(m_64), .MADI_IS96(m_96),
		.MADI_CH_NZ(m_nz), .LED_IN_COAX(in_coax), .LED_IN_AUTO(in_auto), .LED_IN_ERR(in_err),
		.LED_IN_SYNC(in_sync), .LED_IN_64(in64), .LED_IN_96(in96), .LED_IN_AUDIO(in_audio), .WCK_LOCK(wck),
		.IN_SEL_COAX(sel_coax),
		.OUT_FMT_64(fmt64), .OUT_FRAME_96(frm96), .REMOTE_VIA_LINK(rem), .OFFSET_EN(ofs), .AUTO_ASSIGN(auto_a),
		.CLK_SEL(clk_sel), .SPEED_RANGE(spd), .INT_RATE_X10(rate_x10), .AES_REF_IDX(ref_idx), .REF_VALID(ref_ok),
		.LED_CLK(led_clk), .LED_DS(ds), .LED_QS(qs), .NV_STORE(nv_store), .NV_WR_DATA(nv_data), .NV_DONE(nv_done),
		.NV_RESTORE_VALID(rv), .NV_RESTORE_DATA(rdat), .STORE_BUSY(busy), .DP_POS(dp));
	always #10 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// output select, then source or mute
	task automatic route(input logic [6:0] o, input logic [6:0] i, input logic mu);
		o_sel = o;
		o_stb = 1'b1;
		tick(1);
		o_stb = 1'b0;
		i_sel = i;
		i_stb = !mu;
		m_stb = mu;
		tick(1);
		i_stb = 1'b0;
		m_stb = 1'b0;
	endtask
	task automatic look(input logic [6:0] a, input logic [6:0] s, input logic mu);
		rd_addr = a;
		tick(1);
		chk("route_mute", 32'(mu), 32'(rd_mute));
		if (!mu)
			chk("route_src", 32'(s), 32'(rd_src));
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{m_lock, m_64, o_stb, i_stb, m_stb, rv, aes_lock, aes_sync, aes_audio} = '0;
		{m_sync, m_auto, m_96, wck} = '0;
		{o_sel, i_sel, rd_addr, rdat, rate, m_nz} = '0;
		tick(20);
		rst = 1'b0;
		tick(1);
		chk("clk_sel", 32'h10, 32'(clk_sel));
		chk("int_rate", 32'h1E0, 32'(rate_x10));
		foreach (rt[k]) begin
			rate = {4{rt[k]}};
			tick(2);
			chk("led_ds", (rt[k] >= 8'h3C && rt[k] <= 8'h64) ? 32'hF : 32'h0, 32'(led_ds));
			chk("led_qs", (rt[k] >= 8'hA2 && rt[k] <= 8'hC8) ? 32'hF : 32'h0, 32'(led_qs));
		end
		aes_lock = 4'hE;
		wck = 1'b1;
		for (int k = 0; k < 9; k++) begin
			panel_u.press(3);
			chk("clk_sel", 32'h1 << (k % 5), 32'(clk_sel));
			chk("ref_valid", 32'(k % 5 != 1), 32'(ref_ok));
			if (k % 5 != 1)
				chk("led_clk", 32'h1 << (k % 5), 32'(led_clk));
			if (k == 0)
				chk("ref_idx", 32'h1, 32'(ref_idx));
		end
		for (int k = 1; k < 4; k++) begin
			panel_u.press(4);
			chk("speed", k % 3, 32'(spd));
			chk("int_rate", 32'h1B9 << (k % 3), 32'(rate_x10));
			chk("led_ds_sel", 32'(k % 3 == 1), 32'(ds));
			chk("led_qs_sel", 32'(k % 3 == 2), 32'(qs));
		end
		panel_u.press(2);
		chk("frame96", 32'h0, 32'(frm96));
		panel_u.press(4);
		chk("frame96", 32'h1, 32'(frm96));
		panel_u.press(4);
		chk("frame96", 32'h0, 32'(frm96));
		panel_u.press(4);
		panel_u.press(1);
		chk("fmt64", 32'h1, 32'(fmt64));
		panel_u.press(0);
		chk("coax", 32'h1, 32'(sel_coax));
		chk("in_coax", 32'h1, 32'(in_coax));
		panel_u.press(5);
		chk("remote", 32'h1, 32'(rem));
		panel_u.press(7);
		chk("auto", 32'h0, 32'(auto_a));
		panel_u.press(6);
		panel_u.press(7);
		chk("auto", 32'h1, 32'(auto_a));
		panel_u.press(6);
		chk("auto", 32'h0, 32'(auto_a));
		// a change mid-wait must restart the quiet count
		panel_u.dly = 8;
		tick(10);
		panel_u.press(2);
		n = 0;
		while (nv_store !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		chk("quiet_gap", 32'h1, 32'(n >= 18 && n <= 23));
		chk("nv_data", 32'h1A3, 32'(nv_data));
		chk("dp_pos", 32'h1, 32'(dp));
		tick(4);
		chk("busy", 32'h1, 32'(busy));
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		tick(1);
		chk("dp_idle", 32'h0, 32'(dp));
		rdat = 11'h7B1;
		rv = 1'b1;
		tick(1);
		rv = 1'b0;
		tick(2);
		chk("restore", 32'h0000089F, {16'h0, 1'h0, clk_sel, 2'h0, spd, frm96, auto_a, ofs, rem, sel_coax, fmt64});
		chk("ready", 32'h1, 32'(rdy));
		route(7'h05, 7'h09, 1'b0);
		route(7'h06, 7'h09, 1'b0);
		look(7'h05, 7'h09, 1'b0);
		look(7'h06, 7'h09, 1'b0);
		route(7'h05, 7'h0A, 1'b0);
		look(7'h05, 7'h0A, 1'b0);
		route(7'h06, 7'h00, 1'b1);
		look(7'h06, 7'h00, 1'b1);
		route(7'h07, 7'h48, 1'b0);
		look(7'h07, 7'h00, 1'b1);
		look(7'h4A, 7'h00, 1'b1);
		aes_lock = 4'hF;
		aes_sync = 4'h1;
		aes_audio = 4'h2;
		m_lock = 1'b1;
		m_64 = 1'b1;
		m_sync = 1'b1;
		m_auto = 1'b1;
		m_96 = 1'b1;
		m_nz = 64'h0000000000020000;
		tick(2);
		chk("in_audio", 32'h4, 32'(in_audio));
		chk("in_err", 32'h0, 32'(in_err));
		chk("in_64", 32'h1, 32'(in64));
		chk("in_sync", 32'h1, 32'(in_sync));
		chk("in_auto", 32'h1, 32'(in_auto));
		chk("in_96", 32'h1, 32'(in96));
		chk("aes_audio", 32'h2, 32'(led_audio));
		seen = 3'h0;
		repeat (12) begin
			tick(1);
			seen = seen | {led_sync[1], ~led_sync[1], ~led_sync[0]};
		end
		chk("sync_flash", 32'h6, 32'(seen));
		m_lock = 1'b0;
		tick(2);
		chk("in_err", 32'h1, 32'(in_err));
		chk("in_audio", 32'h0, 32'(in_audio));
		chk("in_sync", 32'h0, 32'(in_sync));
		chk("in_96", 32'h0, 32'(in96));
		report_and_stop;
	end
endmodule
`default_nettype wire
